// file: logic/tx_control_pkg.sv
/*
 * Package for the transmit control and hardware configuration register bank:
 * register offsets, field positions, reset values, interrupt layout and the
 * shared FIFO memory split arithmetic.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none

package tx_control_pkg;

	// Byte offsets of the registers on the bus.
	localparam logic [7:0] TRANSMIT_CONTROL_OFFSET       = 8'h70;
	localparam logic [7:0] HARDWARE_CONFIGURATION_OFFSET = 8'h74;
	localparam logic [7:0] INT_STATUS_OFFSET             = 8'h78;
	localparam logic [7:0] INT_MASK_OFFSET               = 8'h7c;

	// Transmit control field positions.
	localparam int TX_STATUS_FLUSH_BIT      = 15;
	localparam int TX_DATA_FLUSH_BIT        = 14;
	localparam int STATUS_OVERRUN_ALLOW_BIT = 2;
	localparam int TX_ENABLE_BIT            = 1;
	localparam int TX_STOP_BIT              = 0;

	// Hardware configuration field positions.
	localparam int CROSSOVER_AUTO_STRAP_BIT = 24;
	localparam int MANDATORY_ONE_BIT_POS    = 20;
	localparam int ALLOC_LSB                = 16;
	localparam int ALLOC_MSB                = 19;

	// Interrupt status and mask layout.
	localparam int INT_STATUS_FULL_BIT = 0;
	localparam int INT_TX_STOPPED_BIT  = 1;
	localparam int INT_WIDTH           = 2;

	// Reset values.
	localparam logic [3:0] ALLOC_RESET         = 4'h5;
	localparam logic       MANDATORY_ONE_RESET = 1'b0;

	// Cycles after reset release before the synchronised strap is captured.
	localparam logic [1:0] STRAP_CAPTURE_COUNT = 2'h2;

	// Memory split constants, in bytes.
	localparam logic [14:0] FIFO_MEMORY_BYTES    = 15'h4000;
	localparam logic [14:0] TX_STATUS_FIFO_BYTES = 15'h0200;
	localparam logic [14:0] RX_FULL_MARGIN_BYTES = 15'h0010;
	localparam int          ALLOC_UNIT_SHIFT     = 10;
	localparam int          RX_STATUS_SHIFT      = 4;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [14:0] tx_data;
		logic [14:0] tx_status;
		logic [14:0] rx_data;
		logic [14:0] rx_status;
		logic [14:0] rx_full;
	} fifo_sizes_s;

	// Splits the shared memory for a given transmit allocation in kilobytes.
	// Reserved allocation codes give meaningless sizes; software must not use them.
	function automatic fifo_sizes_s fifo_split(input logic [3:0] alloc);
		fifo_sizes_s f;
		logic [14:0] tx_total;
		logic [14:0] rx_total;
		tx_total    = 15'({alloc, 10'h000});
		rx_total    = FIFO_MEMORY_BYTES - tx_total;
		f.tx_status = TX_STATUS_FIFO_BYTES;
		f.tx_data   = tx_total - TX_STATUS_FIFO_BYTES;
		f.rx_status = rx_total >> RX_STATUS_SHIFT;
		f.rx_data   = rx_total - f.rx_status;
		f.rx_full   = f.rx_data - RX_FULL_MARGIN_BYTES;
		return f;
	endfunction : fifo_split

endpackage : tx_control_pkg

`default_nettype wire

// file: logic/fifo_split.sv
/*
 * Registered split of the shared FIFO memory between transmit and receive.
 * Assumes the allocation input comes from a register on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module fifo_split_regs (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic [3:0]                 alloc,
	output var  tx_control_pkg::fifo_sizes_s sizes
);
	import tx_control_pkg::*;

	typedef struct packed {
		fifo_sizes_s sizes;
	} split_state_s;

	split_state_s s_r;
	split_state_s s_nxt;

	// Sizes follow the allocation one cycle later.
	always_comb begin
		s_nxt       = s_r;
		s_nxt.sizes = fifo_split(alloc);
	end

	// Reset to the split of the reset allocation so sizes are valid at once.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r.sizes <= fifo_split(ALLOC_RESET);
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sizes = s_r.sizes;

endmodule : fifo_split_regs

`default_nettype wire

// file: logic/tx_control_fifo_config.sv
/*
 * Transmit control and hardware configuration register bank with an AXI4-Lite
 * slave, transmitter enable and graceful stop, FIFO flush strobes, strap
 * readback, FIFO memory split and an interrupt status and mask pair.
 * Assumes the transmit engine, its frame flag and the status FIFO full flag
 * run on clk; the strap pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module tx_control_fifo_config (
	input  wire logic                        clk,
	input  wire logic                        rst,
	// AXI4-Lite slave.
	input  wire logic [7:0]                  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [7:0]                  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	// Strap pin and transmit engine.
	input  wire logic                        crossover_auto_strap,
	input  wire logic                        frame_in_progress,
	input  wire logic                        tx_status_fifo_full,
	output logic                             tx_enabled,
	output logic                             tx_frame_start_allow,
	output logic                             tx_suspend,
	output logic                             tx_status_flush,
	output logic                             tx_data_flush,
	output logic                             mandatory_one_bit,
	output var  tx_control_pkg::fifo_sizes_s fifo_sizes,
	output logic                             irq
);
	import tx_control_pkg::*;

	typedef struct packed {
		logic                 aw_have;
		logic [7:0]           aw_addr;
		logic                 w_have;
		logic [31:0]          w_data;
		logic [3:0]           w_strb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 status_flush;
		logic                 data_flush;
		logic                 status_overrun_allow;
		logic                 tx_on;
		logic                 stop;
		logic                 mandatory_one;
		logic [3:0]           transmit_fifo_allocation;
		logic                 strap_meta;
		logic                 strap_sync;
		logic [1:0]           strap_cnt;
		logic                 strap_val;
		logic                 full_prev;
		logic [INT_WIDTH-1:0] int_status;
		logic [INT_WIDTH-1:0] int_mask;
	} state_s;

	state_s s_r;
	state_s s_nxt;

	// Returns whether a byte address names one of the four registers.
	function automatic logic is_mapped(input logic [7:0] addr);
		return (addr == TRANSMIT_CONTROL_OFFSET) || (addr == HARDWARE_CONFIGURATION_OFFSET) ||
		       (addr == INT_STATUS_OFFSET) || (addr == INT_MASK_OFFSET);
	endfunction : is_mapped

	// Returns the written bits, masked by the byte strobes.
	function automatic logic [31:0] strobed(input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return data & m;
	endfunction : strobed

	// Returns the byte-lane mask of the strobes, so unstrobed bits keep their value.
	function automatic logic [31:0] lanes(input logic [3:0] strb);
		return strobed(32'hffff_ffff, strb);
	endfunction : lanes

	logic        halt;
	logic        full_rise;
	logic        do_write;
	logic [31:0] wbits;
	logic [31:0] wlane;

	// Transmit engine handshake; the suspend is combinational so it reacts to
	// the full flag in the same cycle rather than letting one more status slip.
	assign halt                 = s_r.stop & ~frame_in_progress;
	assign full_rise            = tx_status_fifo_full & ~s_r.full_prev;
	assign tx_suspend           = tx_status_fifo_full & ~s_r.status_overrun_allow;
	assign tx_enabled           = s_r.tx_on;
	assign tx_frame_start_allow = s_r.tx_on & ~s_r.stop & ~tx_suspend;
	assign do_write             = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
	assign wbits                = strobed(s_r.w_data, s_r.w_strb);
	assign wlane                = lanes(s_r.w_strb);

	// Next state: bus channels, register effects, hardware events, strap.
	always_comb begin
		s_nxt              = s_r;
		s_nxt.status_flush = 1'b0;
		s_nxt.data_flush   = 1'b0;
		s_nxt.full_prev    = tx_status_fifo_full;

		// Strap synchroniser; the value is caught once it has settled after reset.
		s_nxt.strap_meta = crossover_auto_strap;
		s_nxt.strap_sync = s_r.strap_meta;
		if (s_r.strap_cnt != 2'h3) begin
			s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
		end
		if (s_r.strap_cnt == STRAP_CAPTURE_COUNT) begin
			s_nxt.strap_val = s_r.strap_sync;
		end

		// Write address and data are accepted independently, one of each at a time.
		if (s_axi_awvalid && !s_r.aw_have) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_have) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end

		if (do_write) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = is_mapped(s_r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_r.aw_addr)
				TRANSMIT_CONTROL_OFFSET: begin
					s_nxt.status_flush = wbits[TX_STATUS_FLUSH_BIT];
					s_nxt.data_flush   = wbits[TX_DATA_FLUSH_BIT];
					if (wlane[STATUS_OVERRUN_ALLOW_BIT]) begin
						s_nxt.status_overrun_allow = wbits[STATUS_OVERRUN_ALLOW_BIT];
					end
					if (wlane[TX_ENABLE_BIT]) begin
						s_nxt.tx_on = wbits[TX_ENABLE_BIT];
					end
					if (!s_r.stop && wbits[TX_STOP_BIT]) begin
						s_nxt.stop = 1'b1;
					end
				end
				HARDWARE_CONFIGURATION_OFFSET: begin
					if (wlane[MANDATORY_ONE_BIT_POS]) begin
						s_nxt.mandatory_one = wbits[MANDATORY_ONE_BIT_POS];
					end
					if (wlane[ALLOC_LSB]) begin
						s_nxt.transmit_fifo_allocation = wbits[ALLOC_MSB:ALLOC_LSB];
					end
				end
				INT_STATUS_OFFSET: begin
					s_nxt.int_status = s_r.int_status & ~wbits[INT_WIDTH-1:0];
				end
				INT_MASK_OFFSET: begin
					if (wlane[0]) begin
						s_nxt.int_mask = wbits[INT_WIDTH-1:0];
					end
				end
				default: begin
					// Unmapped address: nothing is stored.
				end
			endcase
		end

		// The halt wins over a host write in the same cycle, so the engine never
		// sees enable reasserted behind a stop that has just completed.
		if (halt) begin
			s_nxt.stop  = 1'b0;
			s_nxt.tx_on = 1'b0;
			s_nxt.int_status[INT_TX_STOPPED_BIT] = 1'b1;
		end
		// The full event is independent of the overrun policy and beats a clear.
		if (full_rise) begin
			s_nxt.int_status[INT_STATUS_FULL_BIT] = 1'b1;
		end

		// Read channel; reserved and self-clearing bits read as zero.
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = 32'h0000_0000;
			s_nxt.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case (s_axi_araddr)
				TRANSMIT_CONTROL_OFFSET: begin
					s_nxt.rdata[STATUS_OVERRUN_ALLOW_BIT] = s_r.status_overrun_allow;
					s_nxt.rdata[TX_ENABLE_BIT]            = s_r.tx_on;
					s_nxt.rdata[TX_STOP_BIT]              = s_r.stop;
				end
				HARDWARE_CONFIGURATION_OFFSET: begin
					s_nxt.rdata[CROSSOVER_AUTO_STRAP_BIT] = s_r.strap_val;
					s_nxt.rdata[MANDATORY_ONE_BIT_POS]    = s_r.mandatory_one;
					s_nxt.rdata[ALLOC_MSB:ALLOC_LSB]      = s_r.transmit_fifo_allocation;
				end
				INT_STATUS_OFFSET: begin
					s_nxt.rdata[INT_WIDTH-1:0] = s_r.int_status;
				end
				INT_MASK_OFFSET: begin
					s_nxt.rdata[INT_WIDTH-1:0] = s_r.int_mask;
				end
				default: begin
					// Unmapped address reads zero with an error response.
				end
			endcase
		end
	end

	// Synchronous reset to documented defaults; the strap waits for capture.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r                          <= '0;
			s_r.bresp                    <= RESP_OKAY;
			s_r.rresp                    <= RESP_OKAY;
			s_r.mandatory_one            <= MANDATORY_ONE_RESET;
			s_r.transmit_fifo_allocation <= ALLOC_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Memory split derived from the allocation field.
	fifo_split_regs u_split (
		.clk   (clk),
		.rst   (rst),
		.alloc (s_r.transmit_fifo_allocation),
		.sizes (fifo_sizes)
	);

	assign s_axi_awready     = ~s_r.aw_have;
	assign s_axi_wready      = ~s_r.w_have;
	assign s_axi_bvalid      = s_r.bvalid;
	assign s_axi_bresp       = s_r.bresp;
	assign s_axi_arready     = ~s_r.rvalid;
	assign s_axi_rvalid      = s_r.rvalid;
	assign s_axi_rdata       = s_r.rdata;
	assign s_axi_rresp       = s_r.rresp;
	assign tx_status_flush   = s_r.status_flush;
	assign tx_data_flush     = s_r.data_flush;
	assign mandatory_one_bit = s_r.mandatory_one;
	assign irq               = |(s_r.int_status & s_r.int_mask);

endmodule : tx_control_fifo_config

`default_nettype wire

// file: testbench/tx_control_fifo_config_sva.sv
/*
 * Checker for the transmit control bank: engine handshake, flush strobes, bus answers and memory split.
 * Assumes it is bound to the bank, with clk and rst as the bank sees them.
 */
`timescale 1ns/1ps
`default_nettype none

module tx_control_checker (
	input wire logic                        clk,
	input wire logic                        rst,
	input wire logic                        s_axi_awvalid,
	input wire logic                        s_axi_awready,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_arvalid,
	input wire logic                        s_axi_arready,
	input wire logic                        s_axi_rvalid,
	input wire logic                        tx_status_fifo_full,
	input wire logic                        frame_in_progress,
	input wire logic                        tx_enabled,
	input wire logic                        tx_frame_start_allow,
	input wire logic                        tx_suspend,
	input wire logic                        tx_status_flush,
	input wire logic                        tx_data_flush,
	input wire tx_control_pkg::fifo_sizes_s fifo_sizes
);
	import tx_control_pkg::*;

	// All properties share the one clock and its reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Flush strobes are single-cycle so a FIFO is emptied once per write.
	property p_sflush; tx_status_flush |=> !tx_status_flush; endproperty
	a_sflush: assert property (p_sflush) else $error("status flush strobe too long");
	property p_dflush; tx_data_flush |=> !tx_data_flush; endproperty
	a_dflush: assert property (p_dflush) else $error("data flush strobe too long");
	property p_susp; !tx_status_fifo_full |-> !tx_suspend; endproperty
	a_susp: assert property (p_susp) else $error("suspend without full status FIFO");
	property p_nostart; tx_suspend |-> !tx_frame_start_allow; endproperty
	a_nostart: assert property (p_nostart) else $error("frame start while suspended");
	property p_start; tx_frame_start_allow |-> tx_enabled; endproperty
	a_start: assert property (p_start) else $error("frame start while disabled");
	// Enabled, not suspended and yet not allowed to start means a stop is pending.
	property p_halt; tx_enabled && !tx_frame_start_allow && !tx_suspend && !frame_in_progress |=> !tx_enabled; endproperty
	a_halt: assert property (p_halt) else $error("enable kept after halt");
	property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read answer late");
	// Both halves taken together are held for one cycle, then performed, so the answer is two edges on.
	property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |=> ##1 s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write answer late");
	// The split holds in 15-bit arithmetic even for reserved codes, so these never false-fire.
	property p_txs; fifo_sizes.tx_status == 15'h0200; endproperty
	a_txs: assert property (p_txs) else $error("status FIFO size wrong");
	property p_sum; 15'(fifo_sizes.rx_data + fifo_sizes.rx_status + fifo_sizes.tx_data + fifo_sizes.tx_status) == 15'h4000;
	endproperty
	a_sum: assert property (p_sum) else $error("memory split does not add up");
	property p_rxs; fifo_sizes.rx_status == 15'((fifo_sizes.rx_data + fifo_sizes.rx_status) >> 4); endproperty
	a_rxs: assert property (p_rxs) else $error("receive status share wrong");
	property p_rxf; fifo_sizes.rx_full == 15'(fifo_sizes.rx_data - 15'h0010); endproperty
	a_rxf: assert property (p_rxf) else $error("receive full level wrong");

	// Main scenarios.
	c_halt: cover property (tx_enabled ##1 !tx_enabled);
	c_susp: cover property (tx_suspend ##1 !tx_suspend);
	c_flush: cover property (tx_status_flush);

endmodule : tx_control_checker

bind tx_control_fifo_config tx_control_checker i_tx_control_checker (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.tx_status_fifo_full, .frame_in_progress, .tx_enabled, .tx_frame_start_allow, .tx_suspend,
	.tx_status_flush, .tx_data_flush, .fifo_sizes);

`default_nettype wire

// file: testbench/tx_engine_model.sv
/*
 * Behavioural transmit engine: sends fixed-length frames and queues one status word per frame.
 * Assumes the bank's start permission and status flush strobe on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tx_engine_model #(
	parameter int LEN   = 40,
	parameter int DEPTH = 3
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic tx_frame_start_allow,
	input  wire logic tx_status_flush,
	output logic      frame_in_progress,
	output logic      tx_status_fifo_full,
	output var int    frames_sent
);
	int left;
	int occ;

	assign frame_in_progress   = (left != 0);
	assign tx_status_fifo_full = (occ == DEPTH);

	// A frame always runs to its end; a stop only prevents the next start.
	always @(posedge clk) begin
		if (rst) begin
			left <= 0;
			occ <= 0;
			frames_sent <= 0;
		end else begin
			if (left > 1) begin
				left <= left - 1;
			end else if (left == 1) begin
				left <= 0;
				frames_sent <= frames_sent + 1;
				if (occ < DEPTH) occ <= occ + 1;
			end else if (tx_frame_start_allow) begin
				left <= LEN;
			end
			if (tx_status_flush) occ <= 0;
		end
	end

endmodule : tx_engine_model

`default_nettype wire

// file: testbench/tb_tx_control_fifo_config.sv
/*
 * Self-checking bench for the transmit control bank with a behavioural engine on its far side.
 * Assumes the bank package and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_tx_control_fifo_config;
	import tx_control_pkg::*;

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, crossover_auto_strap = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic        frame_in_progress, tx_status_fifo_full, tx_enabled, tx_frame_start_allow, tx_suspend;
	logic        tx_status_flush, tx_data_flush, mandatory_one_bit;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	fifo_sizes_s fifo_sizes;
	int          frames_sent, err_total = 0, checks_done = 0, nsf = 0, ndf = 0;

	always #2.5 clk = ~clk;

	tx_control_fifo_config i_tx_control_fifo_config (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.crossover_auto_strap, .frame_in_progress, .tx_status_fifo_full, .tx_enabled, .tx_frame_start_allow,
		.tx_suspend, .tx_status_flush, .tx_data_flush, .mandatory_one_bit, .fifo_sizes, .irq);
	tx_engine_model #(.LEN(40), .DEPTH(3)) i_tx_engine_model (.clk, .rst, .tx_frame_start_allow,
		.tx_status_flush, .frame_in_progress, .tx_status_fifo_full, .frames_sent);

	// Strobes are counted at the edge, where the pre-edge value is stable.
	always @(posedge clk) begin
		if (tx_status_flush === 1'b1) nsf <= nsf + 1;
		if (tx_data_flush === 1'b1) ndf <= ndf + 1;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n >= 500) begin
			err_total++;
			$display("ERROR wait expected done seen timeout");
			test_done();
		end
	endtask : tmo

	// One bus transfer; readies are sampled mid-cycle so the handshake edge is never raced.
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
		output logic [31:0] q);
		logic ra, rw, rr, rb;
		logic [1:0] rsp;
		int n;
		@(posedge clk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		for (n = 0; n < 500; n++) begin
			@(negedge clk);
			ra = s_axi_awready;
			rw = s_axi_wready;
			rr = s_axi_arready;
			rb = w ? s_axi_bvalid : s_axi_rvalid;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge clk);
			if (ra === 1'b1) s_axi_awvalid <= 1'b0;
			if (rw === 1'b1) s_axi_wvalid <= 1'b0;
			if (rr === 1'b1) s_axi_arvalid <= 1'b0;
			if (rb === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		tmo(n);
		chk("resp", 32'(rsp), 32'(er));
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, RESP_OKAY, q);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, er, q);
		chk("rdata", q, exp);
	endtask : rdc

	task automatic t_reset;
		logic [31:0] q;
		rdc(TRANSMIT_CONTROL_OFFSET, 32'h0, RESP_OKAY);
		rdc(HARDWARE_CONFIGURATION_OFFSET, 32'h0105_0000, RESP_OKAY);
		rdc(INT_STATUS_OFFSET, 32'h0, RESP_OKAY);
		rdc(INT_MASK_OFFSET, 32'h0, RESP_OKAY);
		rdc(8'h80, 32'h0, RESP_SLVERR);
		bus(1'b1, 8'h80, 32'hffff_ffff, RESP_SLVERR, q);
		chk("mandatory_one_bit", 32'(mandatory_one_bit), 32'h0);
		wr(TRANSMIT_CONTROL_OFFSET, 32'hffff_3ff8);
		rdc(TRANSMIT_CONTROL_OFFSET, 32'h0, RESP_OKAY);
		wr(HARDWARE_CONFIGURATION_OFFSET, 32'hfee8_ffff);
		rdc(HARDWARE_CONFIGURATION_OFFSET, 32'h0108_0000, RESP_OKAY);
		$display("test reset and reserved done");
	endtask : t_reset

	// The transmitter stays disabled here, so configuration writes are legal.
	task automatic t_split;
		int a;
		int rx;
		for (a = 2; a <= 14; a++) begin
			rx = 16384 - a * 1024;
			wr(HARDWARE_CONFIGURATION_OFFSET, 32'h0010_0000 | 32'(a << 16));
			rdc(HARDWARE_CONFIGURATION_OFFSET, 32'h0110_0000 | 32'(a << 16), RESP_OKAY);
			chk("tx_data", 32'(fifo_sizes.tx_data), 32'(a * 1024 - 512));
			chk("tx_status", 32'(fifo_sizes.tx_status), 32'd512);
			chk("rx_data", 32'(fifo_sizes.rx_data), 32'(rx - rx / 16));
			chk("rx_status", 32'(fifo_sizes.rx_status), 32'(rx / 16));
			chk("rx_full", 32'(fifo_sizes.rx_full), 32'(rx - rx / 16 - 16));
		end
		chk("mandatory_one_bit", 32'(mandatory_one_bit), 32'h1);
		$display("test split done");
	endtask : t_split

	task automatic t_flush;
		int b;
		int s0;
		int d0;
		for (b = 15; b >= 13; b--) begin
			s0 = nsf;
			d0 = ndf;
			wr(TRANSMIT_CONTROL_OFFSET, 32'h1 << b);
			repeat (2) @(negedge clk);
			chk("status_flush_count", 32'(nsf), 32'(s0 + (b == 15)));
			chk("data_flush_count", 32'(ndf), 32'(d0 + (b == 14)));
			rdc(TRANSMIT_CONTROL_OFFSET, 32'h0, RESP_OKAY);
		end
		$display("test flush done");
	endtask : t_flush

	task automatic t_transmit;
		int n;
		int f;
		wr(INT_MASK_OFFSET, 32'h3);
		rdc(INT_MASK_OFFSET, 32'h3, RESP_OKAY);
		wr(TRANSMIT_CONTROL_OFFSET, 32'h2);
		for (n = 0; n < 500 && tx_status_fifo_full !== 1'b1; n++) @(negedge clk);
		tmo(n);
		chk("frames_sent", 32'(frames_sent), 32'd3);
		f = frames_sent;
		repeat (100) @(negedge clk);
		chk("frames_sent", 32'(frames_sent), 32'(f));
		chk("tx_suspend", 32'(tx_suspend), 32'h1);
		rdc(INT_STATUS_OFFSET, 32'h1, RESP_OKAY);
		chk("irq", 32'(irq), 32'h1);
		wr(TRANSMIT_CONTROL_OFFSET, 32'h6);
		chk("tx_suspend", 32'(tx_suspend), 32'h0);
		for (n = 0; n < 500 && frames_sent <= f; n++) @(negedge clk);
		tmo(n);
		wr(INT_STATUS_OFFSET, 32'h1);
		chk("irq", 32'(irq), 32'h0);
		wr(TRANSMIT_CONTROL_OFFSET, 32'h8006);
		@(negedge clk);
		chk("status_full", 32'(tx_status_fifo_full), 32'h0);
		// Stop is requested early in a frame so the pending state can be read back.
		for (n = 0; n < 500 && frame_in_progress !== 1'b0; n++) @(negedge clk);
		for (; n < 500 && frame_in_progress !== 1'b1; n++) @(negedge clk);
		tmo(n);
		f = frames_sent;
		wr(TRANSMIT_CONTROL_OFFSET, 32'h7);
		rdc(TRANSMIT_CONTROL_OFFSET, 32'h7, RESP_OKAY);
		wr(TRANSMIT_CONTROL_OFFSET, 32'h6);
		rdc(TRANSMIT_CONTROL_OFFSET, 32'h7, RESP_OKAY);
		for (n = 0; n < 500 && tx_enabled !== 1'b0; n++) @(negedge clk);
		tmo(n);
		chk("frames_sent", 32'(frames_sent), 32'(f + 1));
		rdc(TRANSMIT_CONTROL_OFFSET, 32'h4, RESP_OKAY);
		repeat (100) @(negedge clk);
		chk("frames_sent", 32'(frames_sent), 32'(f + 1));
		rdc(INT_STATUS_OFFSET, 32'h2, RESP_OKAY);
		chk("irq", 32'(irq), 32'h1);
		wr(INT_STATUS_OFFSET, 32'h2);
		chk("irq", 32'(irq), 32'h0);
		$display("test transmit done");
	endtask : t_transmit

	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_split();
		t_flush();
		t_transmit();
		test_done();
	end

endmodule : tb_tx_control_fifo_config

`default_nettype wire
